// ===== design/fls_defs.svh
// constants for the fuse, lock and signature store
// assumes one clock domain; values are the unprogrammed/default patterns
`ifndef FLS_DEFS_SVH
`define FLS_DEFS_SVH

// software readback pointer values
`define FLS_PTR_LOW   16'h0000
`define FLS_PTR_LOCK  16'h0001
`define FLS_PTR_EXT   16'h0002
`define FLS_PTR_HIGH  16'h0003

// programmer byte selects
`define FLS_SEL_LOW   2'h0
`define FLS_SEL_LOCK  2'h1
`define FLS_SEL_EXT   2'h2
`define FLS_SEL_HIGH  2'h3
`define FLS_SIG_0     2'h0
`define FLS_SIG_1     2'h1
`define FLS_SIG_2     2'h2
`define FLS_SIG_CAL   2'h3

// reset (default) values
`define FLS_LOCK_RST  8'hff
`define FLS_EXT_RST   8'hff
`define FLS_HIGH_RST  8'hdf
`define FLS_LOW_RST   8'h62

// field positions
`define FLS_LOCK_LO   0
`define FLS_LOCK_HI   1
`define FLS_EXT_SELF  0
`define FLS_HI_RSTD   7
`define FLS_HI_DBG    6
`define FLS_HI_SPI    5
`define FLS_HI_WDT    4
`define FLS_HI_PRES   3
`define FLS_LO_DIV    7
`define FLS_LO_CKO    6
`define FLS_LOCK_KEEP 8'hfc

// cycles from request to answer
`define FLS_ANS_LAT   1

`endif

// ===== design/fls_pkg.sv
// types shared by the fuse, lock and signature store
// assumes the constants header is included where numbers are needed
package fls_pkg;
  typedef enum logic [2:0] {
    FLS_OP_NOP    = 3'b000,
    FLS_OP_WR_CFG = 3'b001,
    FLS_OP_WR_LCK = 3'b010,
    FLS_OP_ERASE  = 3'b011,
    FLS_OP_RD_CFG = 3'b100,
    FLS_OP_RD_SIG = 3'b101
  } fls_op_e;

  typedef enum logic [1:0] {
    FLS_MODE_3 = 2'b00,
    FLS_MODE_X = 2'b01,
    FLS_MODE_2 = 2'b10,
    FLS_MODE_1 = 2'b11
  } fls_lock_mode_e;
endpackage

// ===== design/fls_store.sv
// fuse bytes, lock bits, signature and calibration store
// assumes programmer requests and cpu reads come from mclk logic;
// the two programming-mode pins are asynchronous and get synchronised
`timescale 1ns/1ps
`include "fls_defs.svh"
module fls_store #(
  parameter logic [7:0] SIG_BYTE0 = 8'h5a, // arbitrary identity value
  parameter logic [7:0] SIG_BYTE1 = 8'h3c, // arbitrary identity value
  parameter logic [7:0] SIG_BYTE2 = 8'ha5, // arbitrary identity value
  parameter logic [7:0] OSC_CAL   = 8'h80
) (
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire logic            sys_reset,
  input  wire logic            serial_prog_pin,
  input  wire logic            hv_prog_pin,
  input  wire logic            prog_req,
  input  fls_pkg::fls_op_e     prog_op,
  input  wire logic [1:0]      prog_addr,
  input  wire logic [7:0]      prog_wdata,
  output logic                 prog_ack,
  output logic                 prog_refused,
  output logic [7:0]           prog_rdata,
  output logic                 chip_erase,
  output logic                 erase_data_mem,
  input  wire logic            cpu_rd,
  input  wire logic [15:0]     cpu_ptr,
  output logic                 cpu_rvalid,
  output logic [7:0]           cpu_rdata,
  input  wire logic            trim_wr,
  input  wire logic [7:0]      trim_wdata,
  output logic [7:0]           oscillator_trim_register,
  output logic                 in_prog_mode,
  output logic                 mem_program_allow,
  output logic                 mem_verify_allow,
  output logic                 debug_link_enable,
  output logic                 debug_readout_allow,
  output logic                 data_memory_preserve,
  output logic                 clock_output_enable,
  output logic [3:0]           clock_source_select,
  output logic [1:0]           startup_time_select,
  output logic                 clock_divide_enable,
  output logic                 external_reset_disable,
  output logic                 watchdog_forced_on,
  output logic [2:0]           brownout_level_select,
  output logic                 self_program_enable
);
  import fls_pkg::*;

  fls_sync_if #(.W(2)) pins ();
  logic       ser_s;
  logic       hv_s;
  logic       in_prog;
  logic       prog_entry;
  logic       prog_exit;
  logic       latch_now;
  logic       ok;
  logic       erase_go;
  logic       fuse_locked;

  logic [7:0] lock_q, lock_d, low_q, low_d, high_q, high_d, ext_q, ext_d;
  logic [7:0] cfg_low_q, cfg_low_d, cfg_high_q, cfg_high_d;
  logic [7:0] cfg_ext_q, cfg_ext_d;
  logic       in_prog_q, pwr_pend_q, pwr_pend_d;
  logic       ack_q, ack_d, ref_q, ref_d, erase_q, erase_d, edm_q, edm_d;
  logic [7:0] rdata_q, rdata_d, trim_q, trim_d, crd_q, crd_d;
  logic       cval_q, cval_d;

  // mode pins cross into mclk before anything looks at them
  assign pins.raw = {hv_prog_pin, serial_prog_pin};
  fls_sync #(.W(2)) i_fls_sync (
    .mclk (mclk),
    .rst  (rst),
    .s    (pins)
  );
  assign ser_s = pins.sync[0];
  assign hv_s  = pins.sync[1];

  // session and latch events
  assign in_prog     = ser_s | hv_s;
  assign prog_entry  = in_prog & ~in_prog_q;
  assign prog_exit   = ~in_prog & in_prog_q;
  // exit applies the session's writes; entry and power-up load the image
  assign latch_now   = prog_entry | prog_exit
                       | (pwr_pend_q & ~in_prog);
  assign ok          = prog_req & in_prog;
  assign erase_go    = ok & (prog_op == FLS_OP_ERASE);
  assign fuse_locked = ~lock_q[`FLS_LOCK_LO];

  // nonvolatile image, programmer commands and answers
  always_comb begin
    lock_d  = lock_q;
    low_d   = low_q;
    high_d  = high_q;
    ext_d   = ext_q;
    ack_d   = prog_req;
    ref_d   = prog_req & ~in_prog;
    erase_d = 1'b0;
    edm_d   = 1'b0;
    rdata_d = rdata_q;
    if (ok) begin
      case (prog_op)
        FLS_OP_WR_CFG: begin
          if (fuse_locked || prog_addr == `FLS_SEL_LOCK) begin
            ref_d = 1'b1;
          end else if (prog_addr == `FLS_SEL_LOW) begin
            low_d = prog_wdata;
          end else if (prog_addr == `FLS_SEL_EXT) begin
            ext_d = prog_wdata;
          end else begin
            high_d = prog_wdata;
            // serial session cannot touch its own enable fuse
            if (ser_s && !hv_s) begin
              high_d[`FLS_HI_SPI] = high_q[`FLS_HI_SPI];
            end
          end
        end
        FLS_OP_WR_LCK: begin
          // programming only ever clears lock bits
          lock_d = lock_q & (prog_wdata | `FLS_LOCK_KEEP);
        end
        FLS_OP_ERASE: begin
          lock_d  = `FLS_LOCK_RST;
          erase_d = 1'b1;
          edm_d   = high_q[`FLS_HI_PRES];
        end
        FLS_OP_RD_CFG: begin
          case (prog_addr)
            `FLS_SEL_LOW:  rdata_d = low_q;
            `FLS_SEL_LOCK: rdata_d = lock_q;
            `FLS_SEL_EXT:  rdata_d = ext_q;
            default:       rdata_d = high_q;
          endcase
        end
        FLS_OP_RD_SIG: begin
          case (prog_addr)
            `FLS_SIG_0: rdata_d = SIG_BYTE0;
            `FLS_SIG_1: rdata_d = SIG_BYTE1;
            `FLS_SIG_2: rdata_d = SIG_BYTE2;
            default:    rdata_d = OSC_CAL;
          endcase
        end
        default: ref_d = 1'b1;
      endcase
    end
  end

  // working configuration, only moved on a latch event
  always_comb begin
    cfg_low_d  = cfg_low_q;
    cfg_high_d = cfg_high_q;
    cfg_ext_d  = cfg_ext_q;
    pwr_pend_d = 1'b0;
    if (latch_now) begin
      cfg_low_d  = low_q;
      cfg_high_d = high_q;
      cfg_ext_d  = ext_q;
    end
  end

  // trim register and cpu readback
  always_comb begin
    trim_d = trim_q;
    if (sys_reset) begin
      trim_d = OSC_CAL;
    end else if (trim_wr) begin
      trim_d = trim_wdata;
    end
    cval_d = cpu_rd;
    crd_d  = crd_q;
    if (cpu_rd) begin
      case (cpu_ptr)
        `FLS_PTR_LOW:  crd_d = low_q;
        `FLS_PTR_LOCK: crd_d = lock_q;
        `FLS_PTR_EXT:  crd_d = ext_q;
        `FLS_PTR_HIGH: crd_d = high_q;
        default:       crd_d = 8'hff;
      endcase
    end
  end

  // all state; power reset loads the unprogrammed image
  always_ff @(posedge mclk) begin
    if (rst) begin
      lock_q     <= `FLS_LOCK_RST;
      low_q      <= `FLS_LOW_RST;
      high_q     <= `FLS_HIGH_RST;
      ext_q      <= `FLS_EXT_RST;
      cfg_low_q  <= `FLS_LOW_RST;
      cfg_high_q <= `FLS_HIGH_RST;
      cfg_ext_q  <= `FLS_EXT_RST;
      in_prog_q  <= 1'b0;
      pwr_pend_q <= 1'b1;
      ack_q      <= 1'b0;
      ref_q      <= 1'b0;
      erase_q    <= 1'b0;
      edm_q      <= 1'b0;
      rdata_q    <= 8'h00;
      trim_q     <= OSC_CAL;
      crd_q      <= 8'h00;
      cval_q     <= 1'b0;
    end else begin
      lock_q     <= lock_d;
      low_q      <= low_d;
      high_q     <= high_d;
      ext_q      <= ext_d;
      cfg_low_q  <= cfg_low_d;
      cfg_high_q <= cfg_high_d;
      cfg_ext_q  <= cfg_ext_d;
      in_prog_q  <= in_prog;
      pwr_pend_q <= pwr_pend_d;
      ack_q      <= ack_d;
      ref_q      <= ref_d;
      erase_q    <= erase_d;
      edm_q      <= edm_d;
      rdata_q    <= rdata_d;
      trim_q     <= trim_d;
      crd_q      <= crd_d;
      cval_q     <= cval_d;
    end
  end

  // answers
  assign prog_ack                 = ack_q;
  assign prog_refused             = ref_q;
  assign prog_rdata               = rdata_q;
  assign chip_erase               = erase_q;
  assign erase_data_mem           = edm_q;
  assign cpu_rvalid               = cval_q;
  assign cpu_rdata                = crd_q;
  assign oscillator_trim_register = trim_q;
  assign in_prog_mode             = in_prog_q;

  // protection from the live lock bits
  assign mem_program_allow = lock_q[`FLS_LOCK_LO];
  assign mem_verify_allow  = lock_q[`FLS_LOCK_HI];
  // debug readout follows the fuse alone, which is why locking needs it off
  assign debug_readout_allow = ~cfg_high_q[`FLS_HI_DBG];
  assign debug_link_enable   = ~cfg_high_q[`FLS_HI_DBG]
                               & (&lock_q[1:0]);
  // preserve fuse is read live, not from the latched copy
  assign data_memory_preserve = ~high_q[`FLS_HI_PRES];

  // decoded working configuration, 0 means programmed
  assign clock_output_enable    = ~cfg_low_q[`FLS_LO_CKO];
  assign clock_source_select    = cfg_low_q[3:0];
  assign startup_time_select    = cfg_low_q[5:4];
  assign clock_divide_enable    = ~cfg_low_q[`FLS_LO_DIV];
  assign external_reset_disable = ~cfg_high_q[`FLS_HI_RSTD];
  assign watchdog_forced_on     = ~cfg_high_q[`FLS_HI_WDT];
  assign brownout_level_select  = cfg_high_q[2:0];
  assign self_program_enable    = ~cfg_ext_q[`FLS_EXT_SELF];

  // checks
  a_lock_rise_erase: assert property (@(posedge mclk) disable iff (rst)
    (|(lock_q & ~$past(lock_q))) |-> $past(erase_go))
    else $error("lock bit returned to 1 without erase");
  a_erase_keeps_fuses: assert property (@(posedge mclk) disable iff (rst)
    erase_go |=> $stable(low_q) && $stable(high_q) && $stable(ext_q)
      && lock_q == `FLS_LOCK_RST && chip_erase)
    else $error("erase changed fuses or missed lock reset");
  a_fuse_write_locked: assert property (@(posedge mclk) disable iff (rst)
    ok && prog_op == FLS_OP_WR_CFG && fuse_locked
      |=> prog_refused && prog_ack && $stable(low_q) && $stable(high_q))
    else $error("fuse write accepted while locked");
  a_mode3_blocks: assert property (@(posedge mclk) disable iff (rst)
    lock_q[1:0] == 2'b00 |-> !mem_verify_allow && !mem_program_allow
      && !debug_link_enable)
    else $error("mode 3 left access open");
  a_cfg_hold: assert property (@(posedge mclk) disable iff (rst)
    !latch_now ##1 !$past(rst) |-> $stable(cfg_low_q) && $stable(cfg_high_q))
    else $error("working config moved without latch");
  a_entry_latch: assert property (@(posedge mclk) disable iff (rst)
    prog_entry |=> cfg_high_q == $past(high_q) && cfg_low_q == $past(low_q))
    else $error("entry did not latch fuses");
  a_sig_readback: assert property (@(posedge mclk) disable iff (rst)
    ok && prog_op == FLS_OP_RD_SIG && prog_addr == `FLS_SIG_1
      |=> prog_rdata == SIG_BYTE1 && !prog_refused)
    else $error("signature read wrong or refused");
  a_trim_write: assert property (@(posedge mclk) disable iff (rst)
    trim_wr && !sys_reset |=> oscillator_trim_register == $past(trim_wdata))
    else $error("trim write lost");
  a_trim_copy: assert property (@(posedge mclk) disable iff (rst)
    sys_reset |=> oscillator_trim_register == OSC_CAL)
    else $error("calibration byte not copied on reset");
  a_cpu_lock_read: assert property (@(posedge mclk) disable iff (rst)
    cpu_rd && cpu_ptr == `FLS_PTR_LOCK |=> cpu_rvalid
      && cpu_rdata == $past(lock_q))
    else $error("pointer 1 did not return lock byte");
  a_serial_spi_keep: assert property (@(posedge mclk) disable iff (rst)
    ok && ser_s && !hv_s && prog_op == FLS_OP_WR_CFG
      |=> $stable(high_q[`FLS_HI_SPI]))
    else $error("serial session changed its enable fuse");
  a_erase_preserve: assert property (@(posedge mclk) disable iff (rst)
    erase_go |=> erase_data_mem == !data_memory_preserve)
    else $error("erase data clear disagrees with preserve fuse");

  c_erase: cover property (@(posedge mclk) disable iff (rst) erase_go);
  c_entry: cover property (@(posedge mclk) disable iff (rst) prog_entry);
  c_exit: cover property (@(posedge mclk) disable iff (rst) prog_exit);
  c_mode3: cover property (@(posedge mclk) disable iff (rst)
    lock_q[1:0] == 2'b00);
  c_cpu_rd: cover property (@(posedge mclk) disable iff (rst) cval_q);
endmodule

// ===== design/fls_sync.sv
// two-flop synchroniser for the programming-mode pins
// assumes pins are asynchronous to mclk; first stage read only by second
`timescale 1ns/1ps
module fls_sync #(
  parameter int W = 2
) (
  input  wire logic mclk,
  input  wire logic rst,
  fls_sync_if.sync_side s
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // next values: plain shift
  always_comb begin
    meta_d = s.raw;
    sync_d = meta_q;
  end

  // registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign s.sync = sync_q;
endmodule

// ===== design/fls_sync_if.sv
// carrier between the store and its pin synchroniser
// assumes both ends share mclk
`timescale 1ns/1ps
interface fls_sync_if #(parameter int W = 2);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport sync_side (input raw, output sync);
  modport user_side (output raw, input sync);
endinterface

// ===== testbench/fls_prog_model.sv
// external programmer model: session pins and one-byte requests
// assumes the store samples requests on the rising edge of mclk
`timescale 1ns/1ps
module fls_prog_model
  import fls_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       prog_ack,
  input  wire logic       prog_refused,
  input  wire logic [7:0] prog_rdata,
  output logic            serial_prog_pin,
  output logic            hv_prog_pin,
  output logic            prog_req,
  output fls_op_e         prog_op,
  output logic [1:0]      prog_addr,
  output logic [7:0]      prog_wdata
);
  // idle pins quiet, no session
  initial begin
    serial_prog_pin = 1'b0;
    hv_prog_pin = 1'b0;
    prog_req = 1'b0;
    prog_op = FLS_OP_NOP;
    prog_addr = 2'h0;
    prog_wdata = 8'h00;
  end

  // pin change, then wait out the synchroniser and the entry latch
  task automatic session(input logic hv, input logic on);
    @(negedge mclk);
    if (hv) begin // hv session kept after reset pin disabled
      hv_prog_pin = on;
    end else begin
      serial_prog_pin = on;
    end
    repeat (6) @(negedge mclk);
  endtask

  // one-cycle request; answer taken in its single valid cycle
  task automatic xfer(input fls_op_e op, input logic [1:0] a,
                      input logic [7:0] d, output logic [7:0] rd,
                      output logic rf, output logic ak);
    @(negedge mclk);
    prog_req = 1'b1;
    prog_op = op;
    prog_addr = a;
    prog_wdata = d;
    @(negedge mclk);
    // answer stands only in the cycle after the taking edge
    ak = prog_ack;
    rf = prog_refused;
    rd = prog_rdata;
    prog_req = 1'b0;
    prog_addr = ~a; // released lines do not keep the old value
    prog_wdata = ~d;
  endtask
endmodule

// ===== testbench/tb_fls_store.sv
// self-checking bench for the fuse, lock and signature store
// assumes the programmer model drives the programming port
`timescale 1ns/1ps
`include "fls_defs.svh"
module tb_fls_store;
  import fls_pkg::*;
  localparam logic [7:0] SIG0 = 8'h11; // arbitrary identity value
  localparam logic [7:0] SIG1 = 8'h22; // arbitrary identity value
  localparam logic [7:0] SIG2 = 8'h33; // arbitrary identity value
  localparam logic [7:0] CAL  = 8'h80;
  logic        mclk, rst, sys_reset, cpu_rd, trim_wr;
  logic [15:0] cpu_ptr;
  logic [7:0]  trim_wdata, prog_wdata, prog_rdata, cpu_rdata, trim_q, rd;
  logic        serial_prog_pin, hv_prog_pin, prog_req, prog_ack;
  logic        prog_refused, chip_erase, erase_data_mem, cpu_rvalid;
  logic        in_prog_mode, mem_program_allow, mem_verify_allow, rf, ak;
  logic        debug_link_enable, debug_readout_allow, data_memory_preserve;
  logic        clock_output_enable, clock_divide_enable, self_program_enable;
  logic        external_reset_disable, watchdog_forced_on;
  logic [3:0]  clock_source_select;
  logic [1:0]  startup_time_select, prog_addr;
  logic [2:0]  brownout_level_select;
  fls_op_e     prog_op;
  logic [7:0]  sig [4];
  int          errors, tests_run;

  fls_store #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2),
              .OSC_CAL(CAL)) i_fls_store (
    .mclk(mclk), .rst(rst), .sys_reset(sys_reset),
    .serial_prog_pin(serial_prog_pin), .hv_prog_pin(hv_prog_pin),
    .prog_req(prog_req), .prog_op(prog_op), .prog_addr(prog_addr),
    .prog_wdata(prog_wdata), .prog_ack(prog_ack),
    .prog_refused(prog_refused), .prog_rdata(prog_rdata),
    .chip_erase(chip_erase), .erase_data_mem(erase_data_mem),
    .cpu_rd(cpu_rd), .cpu_ptr(cpu_ptr), .cpu_rvalid(cpu_rvalid),
    .cpu_rdata(cpu_rdata), .trim_wr(trim_wr), .trim_wdata(trim_wdata),
    .oscillator_trim_register(trim_q), .in_prog_mode(in_prog_mode),
    .mem_program_allow(mem_program_allow),
    .mem_verify_allow(mem_verify_allow),
    .debug_link_enable(debug_link_enable),
    .debug_readout_allow(debug_readout_allow),
    .data_memory_preserve(data_memory_preserve),
    .clock_output_enable(clock_output_enable),
    .clock_source_select(clock_source_select),
    .startup_time_select(startup_time_select),
    .clock_divide_enable(clock_divide_enable),
    .external_reset_disable(external_reset_disable),
    .watchdog_forced_on(watchdog_forced_on),
    .brownout_level_select(brownout_level_select),
    .self_program_enable(self_program_enable));

  fls_prog_model i_fls_prog_model (
    .mclk(mclk), .prog_ack(prog_ack), .prog_refused(prog_refused),
    .prog_rdata(prog_rdata), .serial_prog_pin(serial_prog_pin),
    .hv_prog_pin(hv_prog_pin), .prog_req(prog_req), .prog_op(prog_op),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata));

  // free-running 40 MHz clock
  always #12.5 mclk = ~mclk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // cpu readback: pulse on one edge, answer one cycle later
  task automatic cpu_read(input logic [15:0] p, input logic [7:0] exp);
    @(negedge mclk);
    cpu_rd = 1'b1;
    cpu_ptr = p;
    @(negedge mclk);
    check(8'(cpu_rvalid), 8'h01);
    check(cpu_rdata, exp);
    cpu_rd = 1'b0;
  endtask

  // programmer request; every request is answered, refused or not
  task automatic prog(input fls_op_e op, input logic [1:0] a,
                      input logic [7:0] d, input logic exp_rf);
    i_fls_prog_model.xfer(op, a, d, rd, rf, ak);
    check(8'(ak), 8'h01);
    check(8'(rf), 8'(exp_rf));
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard, far beyond the roughly 120 cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    results();
  end

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    sys_reset = 1'b0;
    cpu_rd = 1'b0;
    cpu_ptr = 16'h0;
    trim_wr = 1'b0;
    trim_wdata = 8'h00;
    errors = 0;
    tests_run = 0;
    sig = '{SIG0, SIG1, SIG2, CAL};
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    // power-up image and decoded defaults
    cpu_read(`FLS_PTR_LOW, 8'h62);
    cpu_read(`FLS_PTR_LOCK, 8'hff);
    cpu_read(`FLS_PTR_EXT, 8'hff);
    cpu_read(`FLS_PTR_HIGH, 8'hdf);
    cpu_read(16'h0004, 8'hff);
    check(8'(clock_source_select), 8'h02);
    check(8'(startup_time_select), 8'h02);
    check(8'(clock_output_enable), 8'h00);
    check(8'(mem_program_allow & mem_verify_allow), 8'h01);
    check(trim_q, CAL);
    check({2'h0, clock_divide_enable, external_reset_disable,
           watchdog_forced_on, brownout_level_select}, 8'h27);
    check({4'h0, self_program_enable, in_prog_mode, debug_link_enable,
           data_memory_preserve}, 8'h00);
    check(8'(debug_readout_allow), 8'h00);
    prog(FLS_OP_RD_SIG, `FLS_SIG_0, 8'h00, 1'b1);
    // high-voltage session: signature, calibration, fuse writes
    i_fls_prog_model.session(1'b1, 1'b1);
    check(8'(in_prog_mode), 8'h01);
    prog(FLS_OP_RD_CFG, `FLS_SEL_LOCK, 8'h00, 1'b0);
    check(rd, 8'hff);
    prog(FLS_OP_NOP, 2'h0, 8'h00, 1'b1);
    prog(FLS_OP_WR_CFG, `FLS_SEL_LOCK, 8'h00, 1'b1);
    prog(FLS_OP_WR_CFG, `FLS_SEL_EXT, 8'hfe, 1'b0);
    check(8'(self_program_enable), 8'h00);
    for (int i = 0; i < 4; i++) begin
      prog(FLS_OP_RD_SIG, 2'(i), 8'h00, 1'b0);
      check(rd, sig[i]);
    end
    prog(FLS_OP_WR_CFG, `FLS_SEL_LOW, 8'h22, 1'b0);
    check(8'(clock_output_enable), 8'h00);
    cpu_read(`FLS_PTR_LOW, 8'h22);
    prog(FLS_OP_WR_CFG, `FLS_SEL_HIGH, 8'h97, 1'b0);
    check(8'(data_memory_preserve), 8'h01);
    // exit applies the session's writes, re-entry keeps them
    i_fls_prog_model.session(1'b1, 1'b0);
    check(8'(clock_output_enable), 8'h01);
    check(8'(self_program_enable), 8'h01);
    i_fls_prog_model.session(1'b1, 1'b1);
    check(8'(clock_output_enable), 8'h01);
    check(8'(debug_link_enable), 8'h01);
    // mode 2, then mode 3; debug fuse left on to probe readout
    prog(FLS_OP_WR_LCK, 2'h1, 8'hfe, 1'b0);
    check(8'(mem_program_allow), 8'h00);
    check(8'(mem_verify_allow), 8'h01);
    check(8'(debug_link_enable), 8'h00);
    check(8'(debug_readout_allow), 8'h01);
    prog(FLS_OP_WR_CFG, `FLS_SEL_LOW, 8'hff, 1'b1);
    prog(FLS_OP_WR_LCK, 2'h1, 8'hfd, 1'b0);
    check(8'(mem_verify_allow), 8'h00);
    prog(FLS_OP_RD_SIG, 2'h2, 8'h00, 1'b0);
    check(rd, SIG2);
    prog(FLS_OP_WR_LCK, 2'h1, 8'hff, 1'b0);
    cpu_read(`FLS_PTR_LOCK, 8'hfc);
    // erase with data memory preserved
    prog(FLS_OP_ERASE, 2'h0, 8'h00, 1'b0);
    check({6'h0, chip_erase, erase_data_mem}, 8'h02);
    cpu_read(`FLS_PTR_LOCK, 8'hff);
    cpu_read(`FLS_PTR_LOW, 8'h22);
    // serial session keeps the serial-download fuse, clears the debug fuse
    i_fls_prog_model.session(1'b1, 1'b0);
    i_fls_prog_model.session(1'b0, 1'b1);
    prog(FLS_OP_WR_CFG, `FLS_SEL_HIGH, 8'hff, 1'b0);
    cpu_read(`FLS_PTR_HIGH, 8'hdf);
    prog(FLS_OP_ERASE, 2'h0, 8'h00, 1'b0);
    check({6'h0, chip_erase, erase_data_mem}, 8'h03);
    i_fls_prog_model.session(1'b0, 1'b0);
    // trim write, then chip reset reloads calibration over a write
    @(negedge mclk);
    trim_wr = 1'b1;
    trim_wdata = 8'h3f;
    @(negedge mclk);
    check(trim_q, 8'h3f);
    sys_reset = 1'b1;
    trim_wdata = 8'hc1;
    @(negedge mclk);
    trim_wr = 1'b0;
    sys_reset = 1'b0;
    check(trim_q, CAL);
    results();
  end
endmodule
